// ---- hw/tcp_timer.v ----
// Eight-bit timer with compare register and PWM output, AHB-Lite slave
//
// Design decision made here: the AHB-Lite interface to the registers.
`include "tcp_consts.vh"
module tcp_timer (
  // Clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // AHB-Lite slave
  input wire hsel,
  input wire [9:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Compare output pin
  output reg compare_output_pin,
  output reg compare_output_en,
  // Interrupt requests
  output reg overflow_irq,
  output reg compare_irq
);
  reg [7:0] timer_control;
  reg [7:0] counter_value;
  reg [7:0] compare_threshold;
  reg [7:0] compare_hold;
  reg overflow_flag;
  reg compare_flag;
  reg [2:0] irq_enable;
  reg count_down;
  reg match_q;
  reg wr_pend;
  reg [9:0] wr_addr;
  reg [7:0] next_count;
  reg next_down;
  reg ovf_evt;
  wire tick;
  wire pwm_on;
  wire wrap_sel;
  wire [1:0] action;
  wire match;
  wire bus_take;
  wire [7:0] wbyte;
  wire wr_thresh;
  wire wr_cnt;
  wire wr_ctrl;
  wire wr_flags;
  wire wr_ien;
  wire tmr_act;
  wire force_hit;

  // Register fields
  // mode from enable bit
  assign pwm_on = timer_control[`TCP_B_PWM];
  assign wrap_sel = timer_control[`TCP_B_WRAP];
  assign action = {timer_control[`TCP_B_ACT_HI],
                   timer_control[`TCP_B_ACT_LO]};
  assign match = (counter_value == compare_threshold);

  // Bus decode of the registered data phase
  assign bus_take = hsel && hready && (htrans == `TCP_HTRANS_NSEQ);
  assign wbyte = hwdata[7:0];
  assign wr_thresh = wr_pend && (wr_addr == `TCP_ADDR_THRESH);
  assign wr_cnt = wr_pend && (wr_addr == `TCP_ADDR_CNT);
  assign wr_ctrl = wr_pend && (wr_addr == `TCP_ADDR_CTRL);
  assign wr_flags = wr_pend && (wr_addr == `TCP_ADDR_FLAGS);
  assign wr_ien = wr_pend && (wr_addr == `TCP_ADDR_IEN);
  // Force strobe acts only outside PWM mode
  // force ignored in PWM
  assign force_hit = wr_ctrl && wbyte[`TCP_B_FORCE] && !pwm_on;

  // Prescaler selects the timer tick
  // clock select field
  tcp_prescale u_pre (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clock_select(timer_control[2:0]),
    .tick(tick)
  );
  assign tmr_act = tick && !wr_cnt;

  // Next counter value and overflow event
  always @* begin
    next_count = counter_value;
    next_down = count_down;
    ovf_evt = 1'b0;
    if (pwm_on && !wrap_sel) begin
      if (!count_down) begin
        if (counter_value == `TCP_TOP) begin
          next_down = 1'b1;
          next_count = counter_value - `TCP_ONE8;
        end else begin
          next_count = counter_value + `TCP_ONE8;
        end
      end else if (counter_value == `TCP_BOT) begin
        next_down = 1'b0;
        next_count = counter_value + `TCP_ONE8;
        ovf_evt = 1'b1;
      end else begin
        next_count = counter_value - `TCP_ONE8;
      end
    end else begin
      next_down = 1'b0;
      if (!pwm_on && wrap_sel && match) begin
        next_count = `TCP_BOT;
      end else begin
        next_count = counter_value + `TCP_ONE8;
      end
      ovf_evt = (counter_value == `TCP_TOP);
    end
  end

  // Counter, direction and compare latch
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      counter_value <= `TCP_RST8;
      count_down <= 1'b0;
      compare_threshold <= `TCP_RST8;
    end else begin
      if (wr_cnt) begin
        counter_value <= wbyte;
      end else if (tmr_act) begin
        counter_value <= next_count;
        count_down <= next_down;
      end
      if (!pwm_on) begin
        compare_threshold <= compare_hold;
      end else if (tmr_act && counter_value == `TCP_TOP) begin
        compare_threshold <= compare_hold;
      end
    end
  end

  // Compare pin; mode and action code set the pin enable
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      compare_output_pin <= 1'b0;
      compare_output_en <= 1'b0;
    end else begin
      compare_output_en <= pwm_on ? action[1] : (action != 2'h0);
      if (pwm_on && action[1]) begin
        if (!wrap_sel) begin
          // direction-based action
          // Next direction also covers the turns at 00 and FF
          if (tmr_act && match) begin
            compare_output_pin <= action[0] ^ next_down;
          end
        end else if (compare_threshold == `TCP_TOP) begin
          compare_output_pin <= action[0];
        end else if (tmr_act && match) begin
          compare_output_pin <= action[0];
        end else if (tmr_act && ovf_evt) begin
          compare_output_pin <= !action[0];
        end
      end else if (!pwm_on && ((tmr_act && match) || force_hit)) begin
        case (action)
          2'h1: compare_output_pin <= !compare_output_pin;
          2'h2: compare_output_pin <= 1'b0;
          2'h3: compare_output_pin <= 1'b1;
          default: compare_output_pin <= compare_output_pin;
        endcase
      end
    end
  end

  // Flags: hardware set wins over software clear
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      overflow_flag <= 1'b0;
      compare_flag <= 1'b0;
      match_q <= 1'b0;
    end else begin
      match_q <= tmr_act && match;
      if (match_q) begin
        compare_flag <= 1'b1;
      end else if (wr_flags && wbyte[`TCP_B_CMP]) begin
        compare_flag <= 1'b0;
      end
      if (tmr_act && ovf_evt) begin
        overflow_flag <= 1'b1;
      end else if (wr_flags && wbyte[`TCP_B_OVF]) begin
        overflow_flag <= 1'b0;
      end
    end
  end

  // Interrupt requests
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      overflow_irq <= 1'b0;
      compare_irq <= 1'b0;
    end else begin
      overflow_irq <= overflow_flag && irq_enable[`TCP_B_OVF] &&
                      irq_enable[`TCP_B_GIE];
      compare_irq <= compare_flag && irq_enable[`TCP_B_CMP] &&
                     irq_enable[`TCP_B_GIE];
    end
  end

  // Software registers and bus data phase
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      timer_control <= `TCP_RST8;
      compare_hold <= `TCP_RST8;
      irq_enable <= 3'h0;
      wr_pend <= 1'b0;
      wr_addr <= 10'h000;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend <= bus_take && hwrite;
      if (bus_take) begin
        wr_addr <= haddr;
      end
      // Force bit is a strobe, never stored
      if (wr_ctrl) begin
        timer_control <= {1'b0, wbyte[6:0]};
      end
      if (wr_thresh) begin
        compare_hold <= wbyte;
      end
      if (wr_ien) begin
        irq_enable <= wbyte[2:0];
      end
      // Read data ready for the data phase; unmapped reads zero
      if (bus_take && !hwrite) begin
        case (haddr)
          `TCP_ADDR_THRESH: hrdata <= {24'h000000, compare_hold};
          `TCP_ADDR_CNT: hrdata <= {24'h000000, counter_value};
          `TCP_ADDR_CTRL: hrdata <= {24'h000000, timer_control};
          `TCP_ADDR_FLAGS:
            hrdata <= {30'h0, compare_flag, overflow_flag};
          `TCP_ADDR_IEN: hrdata <= {29'h0, irq_enable};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

// ---- hw/tcp_consts.vh ----
// Register map, field positions and constants of the compare/PWM timer
`ifndef TCP_CONSTS_VH
`define TCP_CONSTS_VH
// Byte addresses (index times four)
`define TCP_IDX_THRESH 8'h23
`define TCP_IDX_CTRL 8'h25
`define TCP_IDX_CNT 8'h24
`define TCP_IDX_FLAGS 8'h26
`define TCP_IDX_IEN 8'h27
`define TCP_ADDR_THRESH 10'h08C
`define TCP_ADDR_CNT 10'h090
`define TCP_ADDR_CTRL 10'h094
`define TCP_ADDR_FLAGS 10'h098
`define TCP_ADDR_IEN 10'h09C
// Control field positions
`define TCP_B_FORCE 7
`define TCP_B_PWM 6
`define TCP_B_ACT_HI 5
`define TCP_B_ACT_LO 4
`define TCP_B_WRAP 3
// Flag and enable bit positions
`define TCP_B_OVF 0
`define TCP_B_CMP 1
`define TCP_B_GIE 2
// Values
`define TCP_RST8 8'h00
`define TCP_TOP 8'hFF
`define TCP_BOT 8'h00
`define TCP_ONE8 8'h01
`define TCP_PRE_W 10
`define TCP_PRE_ZERO 10'h000
`define TCP_PRE_ONE 10'h001
`define TCP_PRE_8 10'h007
`define TCP_PRE_32 10'h01F
`define TCP_PRE_64 10'h03F
`define TCP_PRE_128 10'h07F
`define TCP_PRE_256 10'h0FF
`define TCP_PRE_1024 10'h3FF
`define TCP_HTRANS_NSEQ 2'h2
`endif

// ---- hw/tcp_prescale.v ----
// Clock-select prescaler producing one-cycle timer tick enables
`include "tcp_consts.vh"
module tcp_prescale (
  // Clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // Clock select field
  input wire [2:0] clock_select,
  // Timer tick enable
  output reg tick
);
  reg [`TCP_PRE_W-1:0] div_cnt;
  reg [`TCP_PRE_W-1:0] limit;
  // Terminal count per select code
  always @* begin
    case (clock_select)
      3'h1: limit = `TCP_PRE_ZERO;
      3'h2: limit = `TCP_PRE_8;
      3'h3: limit = `TCP_PRE_32;
      3'h4: limit = `TCP_PRE_64;
      3'h5: limit = `TCP_PRE_128;
      3'h6: limit = `TCP_PRE_256;
      3'h7: limit = `TCP_PRE_1024;
      default: limit = `TCP_PRE_ZERO;
    endcase
  end
  // Free divider; code zero stops the timer
  always @(posedge ref_clk) begin
    if (sys_rst || clock_select == 3'h0) begin
      div_cnt <= `TCP_PRE_ZERO;
      tick <= 1'b0;
    end else if (div_cnt >= limit) begin
      div_cnt <= `TCP_PRE_ZERO;
      tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + `TCP_PRE_ONE;
      tick <= 1'b0;
    end
  end
endmodule

// ---- dv/tcp_timer_assertions.sv ----
// Port checker for the compare/PWM timer
`include "tcp_consts.vh"
module tcp_chk (
  // Clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // Bus
  input wire hsel,
  input wire [9:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  // Pin and requests
  input wire compare_output_pin,
  input wire compare_output_en,
  input wire overflow_irq,
  input wire compare_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic ph;
  logic [9:0] pa, per;
  logic [6:0] c;
  logic [7:0] t;
  logic [2:0] ie;
  logic [10:0] n;
  wire run = c[6] && c[5] && c[2:0] == 3'h1;
  // Shadow of written settings; n counts cycles of unchanged setup
  always_ff @(posedge ref_clk) begin
    ph <= !sys_rst && hready && hsel && htrans == `TCP_HTRANS_NSEQ && hwrite;
    pa <= haddr;
    n <= (n == 11'h7FF) ? n : n + 11'h001;
    if (sys_rst) begin
      c <= 7'h00;
      t <= 8'h00;
      ie <= 3'h0;
      n <= 11'h000;
    end else if (ph && hready) begin
      // Force-only writes keep n, so the stopped check spans them
      if (pa == `TCP_ADDR_CTRL && hwdata[6:0] != c) begin
        c <= hwdata[6:0];
        n <= 11'h000;
      end
      if (pa == `TCP_ADDR_THRESH) begin
        t <= hwdata[7:0];
        n <= 11'h000;
      end
      if (pa == `TCP_ADDR_IEN) ie <= hwdata[2:0];
    end
  end
  // Cycles since the last rising pin edge
  always_ff @(posedge ref_clk)
    per <= $rose(compare_output_pin) ? 10'h001 : per + 10'h001;
  property p_bus; hreadyout && !hresp && hrdata[31:8] == 24'h0; endproperty
  a_bus: assert property (p_bus) else $error("bus answer");
  property p_ovf; (!(ie[0] && ie[2]))[*3] |-> !overflow_irq; endproperty
  a_ovf: assert property (p_ovf) else $error("ovf request");
  property p_cmp; (!(ie[1] && ie[2]))[*3] |-> !compare_irq; endproperty
  a_cmp: assert property (p_cmp) else $error("cmp request");
  property p_off; c[6] && !c[5] && n >= 3 |-> !compare_output_en; endproperty
  a_off: assert property (p_off) else $error("pin driven");
  property p_on; c[6] && c[5] && n >= 3 |-> compare_output_en; endproperty
  a_on: assert property (p_on) else $error("pin idle");
  property p_stop;
    c[6] && c[2:0] == 3'h0 && n >= 3 |-> $stable(compare_output_pin);
  endproperty
  a_stop: assert property (p_stop) else $error("pin moved");
  property p_ff;
    run && c[3] && t == 8'hFF && n >= 600 |-> $stable(compare_output_pin);
  endproperty
  a_ff: assert property (p_ff) else $error("pin not held");
  property p_per;
    $rose(compare_output_pin) && run && n >= 1200
      |-> per == (c[3] ? 10'h100 : 10'h1FE);
  endproperty
  a_per: assert property (p_per) else $error("pwm period");
endmodule
bind tcp_timer tcp_chk i_chk (.*);

// ---- dv/tcp_pin_load.sv ----
// Load on the compare pin, measuring period and high time
module tcp_pin_load (
  // Clock
  input wire ref_clk,
  // Pin as driven
  input wire pin,
  input wire en,
  // Last full cycle seen
  output logic [15:0] period,
  output logic [15:0] high
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] n, h;
  logic lv;
  // Pull-down keeps the line low when undriven
  wire line = en ? pin : 1'b0;
  // Measure from one rising edge to the next
  always @(posedge ref_clk) begin
    lv <= line;
    n <= (line && !lv) ? 16'h0001 : n + 16'h0001;
    h <= (line && !lv) ? 16'h0001 : h + {15'h0000, line};
    if (line && !lv) period <= n;
    if (line && !lv) high <= h;
  end
endmodule

// ---- dv/tcp_timer_tb_top.sv ----
// Testbench for the compare/PWM timer
`include "tcp_consts.vh"
module tcp_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, p;
  logic [9:0] haddr = 10'h000;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, rd;
  logic [15:0] dv [4] = '{16'h0, 16'h1, 16'h8, 16'h20};
  logic [7:0] tc [5] = '{8'h61, 8'h61, 8'h71, 8'h71, 8'h69};
  logic [7:0] tt [5] = '{8'h00, 8'hFF, 8'h00, 8'hFF, 8'hFF};
  logic [4:0] tl = 5'b00110;
  wire [31:0] hrdata;
  wire hreadyout, hresp, pin, en, oirq, cirq;
  wire hready = hreadyout;
  wire [15:0] period, high;
  int n_mismatch = 0, n_checks = 0;
  tcp_timer i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .compare_output_pin(pin),
    .compare_output_en(en), .overflow_irq(oirq), .compare_irq(cirq));
  tcp_pin_load i_load (.ref_clk(ref_clk), .pin(pin), .en(en),
    .period(period), .high(high));
  // Free-running bus clock
  initial forever #12.5 ref_clk = ~ref_clk;
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) n_mismatch++;
    if (got !== exp) $display("Error %0t got %h exp %h", $time, got, exp);
  endtask
  // One single transfer; a stuck hready ends the run
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
    int k;
    hsel <= 1'b1;
    htrans <= `TCP_HTRANS_NSEQ;
    haddr <= a;
    hwrite <= w;
    @(posedge ref_clk);
    for (k = 0; hready !== 1'b1 && k < 9; k++) @(posedge ref_clk);
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    @(posedge ref_clk);
    for (k = 0; hready !== 1'b1 && k < 9; k++) @(posedge ref_clk);
    rd = hrdata;
    if (hready !== 1'b1) n_mismatch++;
    if (hready !== 1'b1) final_report();
  endtask
  task automatic rdc(input logic [9:0] a, input logic [31:0] e);
    bus(1'b0, a, 8'h00);
    chk(rd, e);
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rdc(`TCP_ADDR_THRESH, 32'h0);
    rdc(10'h3FC, 32'h0);
    bus(1'b1, `TCP_ADDR_CTRL, 8'h68);
    bus(1'b1, `TCP_ADDR_THRESH, 8'h40);
    rdc(`TCP_ADDR_THRESH, 32'h40);
    p = pin;
    bus(1'b1, `TCP_ADDR_CTRL, 8'hE8);
    repeat (4) @(posedge ref_clk);
    chk({31'h0, pin}, {31'h0, p});
    rdc(`TCP_ADDR_CTRL, 32'h68);
    // Wrap mode at dividers 1, 8 and 32; high time tracks the threshold
    for (int s = 1; s < 4; s++) begin
      bus(1'b1, `TCP_ADDR_CTRL, 8'h68 | s[7:0]);
      repeat (5 * 256 * dv[s]) @(posedge ref_clk);
      chk({16'h0, period}, {16'h0, 16'h100 * dv[s]});
      p = high >= 16'h40 * dv[s] && high <= 16'h41 * dv[s];
      chk({31'h0, p}, 32'h1);
    end
    rdc(`TCP_ADDR_FLAGS, 32'h3);
    bus(1'b1, `TCP_ADDR_CTRL, 8'h79);
    repeat (1300) @(posedge ref_clk);
    p = high >= 16'h0BF && high <= 16'h0C0;
    chk({31'h0, p}, 32'h1);
    // Up/down, both polarities
    bus(1'b1, `TCP_ADDR_CTRL, 8'h61);
    repeat (2600) @(posedge ref_clk);
    chk({16'h0, period, high}, 32'h01FE0080);
    bus(1'b1, `TCP_ADDR_CTRL, 8'h71);
    repeat (2600) @(posedge ref_clk);
    chk({16'h0, period, high}, 32'h01FE017E);
    rdc(`TCP_ADDR_FLAGS, 32'h3);
    bus(1'b1, `TCP_ADDR_IEN, 8'h03);
    repeat (4) @(posedge ref_clk);
    chk({30'h0, oirq, cirq}, 32'h0);
    bus(1'b1, `TCP_ADDR_IEN, 8'h07);
    repeat (4) @(posedge ref_clk);
    chk({30'h0, oirq, cirq}, 32'h3);
    bus(1'b1, `TCP_ADDR_CTRL, 8'h60);
    bus(1'b1, `TCP_ADDR_FLAGS, 8'h03);
    rdc(`TCP_ADDR_FLAGS, 32'h0);
    // Extreme thresholds give a fixed level
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, `TCP_ADDR_CTRL, tc[i]);
      bus(1'b1, `TCP_ADDR_THRESH, tt[i]);
      repeat (1100) @(posedge ref_clk);
      chk({31'h0, pin}, {31'h0, tl[i]});
    end
    // Codes 00 and 01 in both counting modes release the pin
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, `TCP_ADDR_CTRL, {3'h2, i[1:0], 3'h1});
      repeat (4) @(posedge ref_clk);
      chk({31'h0, en}, 32'h0);
    end
    final_report();
  end
endmodule
